// ---- design/sfcd_defs.svh ----
// opcode values, byte counts and field sizes for the serial flash command decoder
// assumes: included by the package and by every design file that decodes commands
`ifndef SFCD_DEFS_SVH
`define SFCD_DEFS_SVH

`define SFCD_OP_SET_WL      8'h06
`define SFCD_OP_CLR_WL      8'h04
`define SFCD_OP_RD_ID       8'h9F
`define SFCD_OP_RD_SIG      8'hAB
`define SFCD_OP_FBOOST      8'h41
`define SFCD_OP_RD_MD       8'h90
`define SFCD_OP_RST_ARM     8'h66
`define SFCD_OP_RST_FIRE    8'h99
`define SFCD_OP_PAGE_WR     8'h02
`define SFCD_OP_SECT_WIPE   8'h20
`define SFCD_OP_HALF_WIPE   8'h52
`define SFCD_OP_BLK_WIPE    8'hD8
`define SFCD_OP_CHIP_WIPE_A 8'h60
`define SFCD_OP_CHIP_WIPE_B 8'hC7
`define SFCD_OP_STAT_WR     8'h01
`define SFCD_OP_STAT_RD     8'h05
`define SFCD_OP_SLEEP       8'hB9
`define SFCD_OP_RD_NORM     8'h03
`define SFCD_OP_RD_FAST     8'h0B
`define SFCD_OP_RD_DUAL     8'h3B
`define SFCD_OP_RD_PARAM    8'h5A

// byte counts include the opcode byte
`define SFCD_BYTES_BARE     4'h1
`define SFCD_HDR_LAST       4'h3
`define SFCD_HDR_BYTES      4'h4
`define SFCD_PAGE_MIN       4'h5
`define SFCD_STWR_SHORT     4'h2
`define SFCD_STWR_LONG      4'h3
`define SFCD_BYTE_MAX       4'hF
`define SFCD_BIT_LAST       3'h7
`define SFCD_BIT_FIRST      3'h0
`define SFCD_ID_LAST        5'h17
`define SFCD_DUMMY_FAST     4'h8
`define SFCD_DUMMY_NONE     4'h0
`define SFCD_MD_ADDR_SWAP   8'h01

`endif

// ---- design/sfcd_pkg.sv ----
// types shared by the command decoder modules
// assumes: sfcd_defs.svh on the include path
package sfcd_pkg;
  `include "sfcd_defs.svh"

  typedef enum logic [2:0] {
    ST_IGN  = 3'h0,
    ST_OPC  = 3'h1,
    ST_HDR  = 3'h3,
    ST_OUT  = 3'h2,
    ST_PASS = 3'h6
  } sfcd_state_t;

  typedef enum logic [3:0] {
    CL_BARE, CL_ADDR_RD, CL_ADDR_WR, CL_ID, CL_STAT, CL_SIG, CL_MD, CL_STWR, CL_BAD
  } sfcd_cls_t;

  typedef enum logic [1:0] {
    OK_ID, OK_SIG, OK_MD, OK_STAT
  } sfcd_out_t;
endpackage

// ---- design/sfcd_pin_if.sv ----
// conditioned pin events passed from the pin sampler to the decoder core
// assumes: one clock domain, events are one-cycle pulses
`timescale 1ns/1ps
interface sfcd_pin_if;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si;
  modport src (output cs_low, cs_fall, cs_rise, sck_rise, sck_fall, si);
  modport dst (input cs_low, cs_fall, cs_rise, sck_rise, sck_fall, si);
endinterface

// ---- design/sfcd_pin_sync.sv ----
// three-stage sampler for chip select, serial clock and serial in, edge finder for chip select and serial clock
// assumes: pins asynchronous to clk, serial clock well below clk/6
`timescale 1ns/1ps
module sfcd_pin_sync
(
  // system
  input  wire logic clk,
  input  wire logic rst,
  // raw pins
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic si,
  // conditioned events
  sfcd_pin_if.src   p
);
  logic [2:0] raw;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] flt_r;
  logic [2:0] prv_r;

  assign raw = {si, sclk, cs_n};

  ////////////////////////////////////////////////////////////////////////
  // same pipeline depth on all three keeps data aligned with clock edges
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1_r[i]  <= (i == 0);
          s2_r[i]  <= (i == 0);
          s3_r[i]  <= (i == 0);
          flt_r[i] <= (i == 0);
          prv_r[i] <= (i == 0);
        end
        else
        begin
          s1_r[i]  <= raw[i];
          s2_r[i]  <= s1_r[i];
          s3_r[i]  <= s2_r[i];
          flt_r[i] <= (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
          prv_r[i] <= flt_r[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  assign p.cs_low   = ~flt_r[0];
  assign p.cs_fall  = ~flt_r[0] & prv_r[0];
  assign p.cs_rise  = flt_r[0] & ~prv_r[0];
  assign p.sck_rise = flt_r[1] & ~prv_r[1];
  assign p.sck_fall = ~flt_r[1] & prv_r[1];
  assign p.si       = flt_r[2];
endmodule

// ---- design/sfcd_top.sv ----
// serial flash command decoder: opcode decode, latch flags, id readouts, array handoff
// assumes: array sequencer on clk reports busy level and one-cycle done pulse
// Behaviour
// R1: set-write-latch opcode in one select frame sets the write latch.
// R2: content-changing commands launch only while the write latch is set.
// R3: clear-write-latch opcode resets the write latch.
// R4: latch clears at reset, on clear command, and on completion of writes.
// R5: upper data lines are never sampled during single-line commands.
// R6: identification read shifts maker then two device bytes, 24 bits, stoppable anytime.
// R7: identification read is not decoded while busy; select high returns standby.
// R8: signature read repeats the 8-bit signature while the host keeps clocking.
// R9: bare signature opcode releases deep sleep.
// R10: host should prefer the three-byte identification read over signature.
// R11: factory-boost opcode sets the factory flag.
// R12: factory flag clears at reset and on erase or program completion.
// R13: maker-device read takes two dummies, one address, shifts msb first on falls.
// R14: address 00h gives maker first, 01h gives device first.
// R15: maker and device bytes alternate until select rises.
// R16: reset-fire acts only directly after reset-arm.
// R17: host should send only defined opcodes; others may reach hidden modes.
// R18: maker-device read takes one address byte, returns two bytes per pass.
// R19: inputs sampled on rising serial clock, outputs driven on falling edge.
// R20: bare, wipe, write and sleep commands need select high on a byte boundary.
// R21: unknown opcode leaves output off until the next select fall.
// R22: signature read has three dummy bytes; opcodes are one byte msb first.
// R23: array opcodes are handed off with address and dummy count.
`timescale 1ns/1ps
`include "sfcd_defs.svh"
module sfcd_top
#(
  parameter logic [7:0] MAKER_ID  = 8'h3C, // arbitrary
  parameter logic [7:0] MEM_TYPE  = 8'h11, // arbitrary
  parameter logic [7:0] MEM_DENS  = 8'h15, // arbitrary
  parameter logic [7:0] DEVICE_ID = 8'h13  // arbitrary, also the signature
)
(
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // array sequencer
  input  wire logic        arr_busy,
  input  wire logic        arr_done,
  input  wire logic [5:0]  stat_hi,
  output logic             arr_start,
  output logic [7:0]       arr_op,
  output logic [23:0]      arr_addr,
  output logic [3:0]       arr_dummy,
  output logic [7:0]       rx_byte,
  output logic             rx_vld,
  // control state
  output logic             write_latch_bit,
  output logic             factory_mode,
  output logic             deep_sleep,
  output logic             soft_reset
);
  import sfcd_pkg::*;

  sfcd_pin_if p ();

  sfcd_pin_sync u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .cs_n (cs_n),
    .sclk (sclk),
    .si   (si),
    .p    (p)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic sfcd_cls_t sfcd_cls(input logic [7:0] op);
    case (op)
      `SFCD_OP_SET_WL, `SFCD_OP_CLR_WL, `SFCD_OP_FBOOST, `SFCD_OP_RST_ARM,
      `SFCD_OP_RST_FIRE, `SFCD_OP_SLEEP, `SFCD_OP_CHIP_WIPE_A,
      `SFCD_OP_CHIP_WIPE_B:                    sfcd_cls = CL_BARE;
      `SFCD_OP_RD_NORM, `SFCD_OP_RD_FAST, `SFCD_OP_RD_DUAL,
      `SFCD_OP_RD_PARAM:                       sfcd_cls = CL_ADDR_RD;
      `SFCD_OP_PAGE_WR, `SFCD_OP_SECT_WIPE, `SFCD_OP_HALF_WIPE,
      `SFCD_OP_BLK_WIPE:                       sfcd_cls = CL_ADDR_WR;
      `SFCD_OP_RD_ID:                          sfcd_cls = CL_ID;
      `SFCD_OP_STAT_RD:                        sfcd_cls = CL_STAT;
      `SFCD_OP_RD_SIG:                         sfcd_cls = CL_SIG;
      `SFCD_OP_RD_MD:                          sfcd_cls = CL_MD;
      `SFCD_OP_STAT_WR:                        sfcd_cls = CL_STWR;
      default:                                 sfcd_cls = CL_BAD;
    endcase
  endfunction

  function automatic logic [7:0] sfcd_out_byte(input sfcd_out_t k, input logic [4:0] c,
                                               input logic swap, input logic [7:0] st);
    case (k)
      OK_ID:   sfcd_out_byte = (c[4:3] == 2'h0) ? MAKER_ID : (c[4:3] == 2'h1) ? MEM_TYPE : MEM_DENS;
      OK_SIG:  sfcd_out_byte = DEVICE_ID;
      OK_MD:   sfcd_out_byte = (c[3] ^ swap) ? DEVICE_ID : MAKER_ID;
      default: sfcd_out_byte = st;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  sfcd_state_t st_r;
  sfcd_state_t st_nxt;
  sfcd_out_t   kind_r;
  logic [7:0]  sh_r;
  logic [2:0]  bitp_r;
  logic [3:0]  bytes_r;
  logic [7:0]  opc_r;
  logic [23:0] addr_r;
  logic [4:0]  ocnt_r;
  logic        md_swap_r;
  logic        wel_r;
  logic        fact_r;
  logic        sleep_r;
  logic        arm_r;
  logic        op_stat_r;
  logic        so_r;
  logic        so_oe_r;
  logic        start_r;
  logic [7:0]  aop_r;
  logic [23:0] aaddr_r;
  logic [3:0]  adum_r;
  logic [7:0]  rxb_r;
  logic        rxv_r;
  logic        srst_r;

  logic [7:0]  new_byte;
  logic        byte_done;
  sfcd_cls_t   cls_new;
  sfcd_cls_t   cls_cur;
  logic        hdr_last;
  logic        end_ok;
  logic        bare_end;
  logic        do_set;
  logic        do_clr;
  logic        do_fact;
  logic        do_arm;
  logic        do_fire;
  logic        do_sleep;
  logic        do_wake;
  logic        chip_end;
  logic        wipe_end;
  logic        page_end;
  logic        stwr_end;
  logic        wr_launch;
  logic        rd_launch;
  logic        wr_done;
  logic [7:0]  stat_byte;
  logic [7:0]  cur_out;
  logic        ocnt_wrap;

  // R5 R22 only the single serial input feeds the shifter, msb first
  assign new_byte  = {sh_r[6:0], p.si};
  assign byte_done = p.sck_rise && p.cs_low && (bitp_r == `SFCD_BIT_LAST);
  assign cls_new   = sfcd_cls(new_byte);
  assign cls_cur   = sfcd_cls(opc_r);
  assign hdr_last  = byte_done && (st_r == ST_HDR) && (bytes_r == `SFCD_HDR_LAST);

  // R20 completion only when select rises on a byte boundary
  assign end_ok    = p.cs_rise && (st_r == ST_HDR) && (bitp_r == `SFCD_BIT_FIRST);
  assign bare_end  = end_ok && (bytes_r == `SFCD_BYTES_BARE);
  assign do_set    = bare_end && (opc_r == `SFCD_OP_SET_WL);
  assign do_clr    = bare_end && (opc_r == `SFCD_OP_CLR_WL);
  assign do_fact   = bare_end && (opc_r == `SFCD_OP_FBOOST);
  assign do_arm    = bare_end && (opc_r == `SFCD_OP_RST_ARM);
  assign do_sleep  = bare_end && (opc_r == `SFCD_OP_SLEEP);
  // R16 fire counts only with the arm flag from the previous command
  assign do_fire   = bare_end && (opc_r == `SFCD_OP_RST_FIRE) && arm_r;
  // R9 bare signature opcode wakes from sleep
  assign do_wake   = bare_end && (opc_r == `SFCD_OP_RD_SIG);
  assign chip_end  = bare_end && ((opc_r == `SFCD_OP_CHIP_WIPE_A) || (opc_r == `SFCD_OP_CHIP_WIPE_B));
  assign wipe_end  = end_ok && (cls_cur == CL_ADDR_WR) && (opc_r != `SFCD_OP_PAGE_WR)
                     && (bytes_r == `SFCD_HDR_BYTES);
  assign page_end  = end_ok && (opc_r == `SFCD_OP_PAGE_WR) && (bytes_r >= `SFCD_PAGE_MIN);
  assign stwr_end  = end_ok && (cls_cur == CL_STWR)
                     && ((bytes_r == `SFCD_STWR_SHORT) || (bytes_r == `SFCD_STWR_LONG));
  // R2 content changes need the latch and an idle array
  assign wr_launch = (chip_end || wipe_end || page_end || stwr_end) && wel_r && !arr_busy;
  // R23 reads leave once the third address byte is in
  assign rd_launch = hdr_last && (cls_cur == CL_ADDR_RD) && !arr_busy;
  assign wr_done   = arr_done;

  assign stat_byte = {stat_hi, wel_r, arr_busy};
  assign cur_out   = sfcd_out_byte(kind_r, ocnt_r, md_swap_r, stat_byte);
  // R6 identification wraps after its 24 bits
  assign ocnt_wrap = (kind_r == OK_ID) && (ocnt_r == `SFCD_ID_LAST);

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    if (p.cs_fall)
      st_nxt = ST_OPC;
    // R21 select high always parks in standby
    else if (!p.cs_low)
      st_nxt = ST_IGN;
    else if (byte_done)
    begin
      case (st_r)
        ST_OPC:
        begin
          if (sleep_r && (new_byte != `SFCD_OP_RD_SIG))
            st_nxt = ST_IGN;
          else
          begin
            case (cls_new)
              // R7 identification read not decoded while busy
              CL_ID:   st_nxt = arr_busy ? ST_IGN : ST_OUT;
              CL_STAT: st_nxt = ST_OUT;
              // R21 unknown opcode goes quiet
              CL_BAD:  st_nxt = ST_IGN;
              default: st_nxt = ST_HDR;
            endcase
          end
        end
        ST_HDR:
        begin
          if (bytes_r == `SFCD_HDR_LAST)
          begin
            case (cls_cur)
              CL_ADDR_RD:   st_nxt = arr_busy ? ST_IGN : ST_PASS;
              // R22 R13 signature and maker-device outputs after three bytes
              CL_SIG, CL_MD: st_nxt = ST_OUT;
              default:      st_nxt = ST_HDR;
            endcase
          end
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || srst_r)
      st_r <= ST_IGN;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // R19 input shifter advances on rising serial clock
  always_ff @(posedge clk)
  begin
    if (rst || p.cs_fall)
    begin
      sh_r    <= 8'h00;
      bitp_r  <= `SFCD_BIT_FIRST;
      bytes_r <= 4'h0;
    end
    else if (p.sck_rise && p.cs_low)
    begin
      sh_r    <= new_byte;
      bitp_r  <= bitp_r + 3'h1;
      bytes_r <= (byte_done && bytes_r != `SFCD_BYTE_MAX) ? bytes_r + 4'h1 : bytes_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      opc_r     <= 8'h00;
      addr_r    <= 24'h000000;
      md_swap_r <= 1'b0;
      kind_r    <= OK_STAT;
    end
    else if (byte_done && st_r == ST_OPC)
    begin
      opc_r  <= new_byte;
      kind_r <= (cls_new == CL_ID) ? OK_ID : OK_STAT;
    end
    else if (byte_done && st_r == ST_HDR && bytes_r < `SFCD_HDR_BYTES)
    begin
      addr_r    <= {addr_r[15:0], new_byte};
      // R14 R18 address byte picks which id leads
      md_swap_r <= (new_byte == `SFCD_MD_ADDR_SWAP);
      kind_r    <= (cls_cur == CL_MD) ? OK_MD : (cls_cur == CL_SIG) ? OK_SIG : kind_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // R19 R13 output bits change on falling serial clock, msb first
  always_ff @(posedge clk)
  begin
    if (rst || p.cs_fall)
    begin
      ocnt_r <= 5'h00;
      so_r   <= 1'b0;
    end
    else if (p.sck_fall && st_r == ST_OUT)
    begin
      so_r   <= cur_out[~ocnt_r[2:0]];
      // R8 R15 signature repeats, maker/device alternate
      ocnt_r <= ocnt_wrap ? 5'h00 : ocnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      so_oe_r <= 1'b0;
    else
      so_oe_r <= p.cs_low && (st_r == ST_OUT) && (so_oe_r || p.sck_fall);
  end

  ////////////////////////////////////////////////////////////////////////
  // R1 R3 R4 latch; a set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (rst || srst_r)
      wel_r <= 1'b0;
    else if (do_set)
      wel_r <= 1'b1;
    else if (do_clr || wr_done)
      wel_r <= 1'b0;
  end

  // R11 R12 factory flag
  always_ff @(posedge clk)
  begin
    if (rst || srst_r)
      fact_r <= 1'b0;
    else if (do_fact)
      fact_r <= 1'b1;
    else if (wr_done && !op_stat_r)
      fact_r <= 1'b0;
  end

  // R16 arm flag dropped by any other completed command
  always_ff @(posedge clk)
  begin
    if (rst || srst_r)
      arm_r <= 1'b0;
    else if (p.cs_rise && bytes_r != 4'h0)
      arm_r <= do_arm;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleep_r <= 1'b0;
      srst_r  <= 1'b0;
    end
    else
    begin
      sleep_r <= do_sleep ? 1'b1 : (do_wake || srst_r) ? 1'b0 : sleep_r;
      srst_r  <= do_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // R23 handoff to the array sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_r   <= 1'b0;
      aop_r     <= 8'h00;
      aaddr_r   <= 24'h000000;
      adum_r    <= `SFCD_DUMMY_NONE;
      op_stat_r <= 1'b0;
    end
    else
    begin
      start_r <= wr_launch || rd_launch;
      if (wr_launch || rd_launch)
      begin
        aop_r     <= opc_r;
        aaddr_r   <= rd_launch ? {addr_r[15:0], new_byte} : addr_r;
        adum_r    <= (rd_launch && opc_r != `SFCD_OP_RD_NORM) ? `SFCD_DUMMY_FAST : `SFCD_DUMMY_NONE;
        op_stat_r <= (cls_cur == CL_STWR);
      end
    end
  end

  // data bytes after the header, for page and status writes and read passthrough
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxb_r <= 8'h00;
      rxv_r <= 1'b0;
    end
    else
    begin
      rxv_r <= byte_done && ((st_r == ST_PASS) || ((st_r == ST_HDR)
               && ((bytes_r >= `SFCD_HDR_BYTES) || (cls_cur == CL_STWR))));
      rxb_r <= byte_done ? new_byte : rxb_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign so              = so_r;
  assign so_oe           = so_oe_r;
  assign arr_start       = start_r;
  assign arr_op          = aop_r;
  assign arr_addr        = aaddr_r;
  assign arr_dummy       = adum_r;
  assign rx_byte         = rxb_r;
  assign rx_vld          = rxv_r;
  assign write_latch_bit = wel_r;
  assign factory_mode    = fact_r;
  assign deep_sleep      = sleep_r;
  assign soft_reset      = srst_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_opc_taken;
    byte_done && (st_r == ST_OPC);
  endsequence

  sequence s_arm_done;
    do_arm ##1 !srst_r;
  endsequence

  AST_SET_LATCH: assert property (do_set |=> write_latch_bit) // R1
    else $error("set command did not raise latch");
  AST_CLR_LATCH: assert property (do_clr |=> !write_latch_bit) // R3
    else $error("clear command left latch set");
  AST_WR_NEEDS_LATCH: assert property ($rose(arr_start) && aop_r != `SFCD_OP_RD_NORM
    && aop_r != `SFCD_OP_RD_FAST && aop_r != `SFCD_OP_RD_DUAL && aop_r != `SFCD_OP_RD_PARAM
    |-> $past(wel_r)) // R2
    else $error("write launched without latch");
  AST_DONE_CLR: assert property (arr_done && !do_set |=> !write_latch_bit) // R4
    else $error("completion kept latch");
  AST_FACT_CLR: assert property (arr_done && !op_stat_r && !do_fact |=> !factory_mode) // R12
    else $error("completion kept factory flag");
  AST_FIRE_ARMED: assert property ($rose(soft_reset) |-> $past(arm_r, 2)) // R16
    else $error("reset fired without arm");
  AST_ARM_FIRE: assert property (s_arm_done |-> arm_r) // R16
    else $error("arm flag not held");
  AST_ID_BUSY: assert property (s_opc_taken ##0 ((cls_new == CL_ID) && arr_busy && p.cs_low)
    |=> st_r == ST_IGN ##1 !so_oe) // R7
    else $error("id decoded while busy");
  AST_IGN_QUIET: assert property (st_r == ST_IGN && !p.cs_fall |=> !so_oe) // R21
    else $error("output on in standby");
  AST_BOUNDARY: assert property (p.cs_rise && bitp_r != `SFCD_BIT_FIRST |=> !arr_start) // R20
    else $error("launch off byte boundary");
  AST_OPC_MSB: assert property (s_opc_taken |=> opc_r == $past(new_byte)) // R22
    else $error("opcode not captured");
endmodule

// ---- verif/sfcd_host_model.sv ----
// host serial controller model: idle-low clock, whole-bit frames, msb first
// assumes: clk is the device clock; serial half period of 4 clocks (160 ns period)
`timescale 1ns/1ps
module sfcd_host_model
(
  // system
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  logic so_pin;

  // released output reads as the inverse, never as a stale copy
  assign so_pin = so_oe ? so : ~so;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b1;
  end

  // si set while clock low, msb first, select raised after whole bits
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      si <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      // sample just before the fall: holds the bit launched at the previous fall
      rx = {rx[62:0], so_pin};
      sclk <= 1'b0;
    end
    repeat (7) @(posedge clk);
    rx = {rx[62:0], so_pin};
    cs_n <= 1'b1;
    si   <= ~si;
    // gap covers the pin filters and select-high spacing
    repeat (10) @(posedge clk);
  endtask
endmodule

// ---- verif/sfcd_top_bench.sv ----
// self-checking bench for the command decoder: host model on the pins, bench as array sequencer
// assumes: default parameter set of sfcd_top overridden with the values below
`timescale 1ns/1ps
module sfcd_top_bench;
  import sfcd_pkg::*;
  // arbitrary identification values
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] MT = 8'h11;
  localparam logic [7:0] MD = 8'h15;
  localparam logic [7:0] DV = 8'h13;
  logic        clk, rst, cs_n, sclk, si, so, so_oe, arr_busy, arr_done, arr_start, rx_vld;
  logic        write_latch_bit, factory_mode, deep_sleep, soft_reset, oe_seen;
  logic [5:0]  stat_hi;
  logic [7:0]  arr_op, rx_byte, op;
  logic [23:0] arr_addr, addr;
  logic [3:0]  arr_dummy;
  logic [63:0] rx, d;
  int          errors, num_checks, starts, resets, rxs, s0;

  sfcd_host_model i_sfcd_host_model (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
  sfcd_top #(.MAKER_ID(MK), .MEM_TYPE(MT), .MEM_DENS(MD), .DEVICE_ID(DV)) i_sfcd_top (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
    .arr_busy(arr_busy), .arr_done(arr_done), .stat_hi(stat_hi), .arr_start(arr_start),
    .arr_op(arr_op), .arr_addr(arr_addr), .arr_dummy(arr_dummy), .rx_byte(rx_byte), .rx_vld(rx_vld),
    .write_latch_bit(write_latch_bit), .factory_mode(factory_mode), .deep_sleep(deep_sleep),
    .soft_reset(soft_reset));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (arr_start === 1'b1) starts++;
    if (soft_reset === 1'b1) resets++;
    if (rx_vld === 1'b1) rxs++;
    if (so_oe !== 1'b0) oe_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send(input logic [63:0] tx, input int nbits);
    oe_seen <= 1'b0;
    i_sfcd_host_model.frame(tx, nbits, rx);
    d = rx >> 1;
  endtask

  // stands in for the array sequencer finishing a write or erase
  task automatic finish_op;
    arr_busy <= 1'b1;
    repeat (8) @(posedge clk);
    arr_busy <= 1'b0;
    arr_done <= 1'b1;
    @(posedge clk);
    arr_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] md_exp(input logic [7:0] a);
    return (a == 8'h01) ? {DV, MK, DV, MK} : {MK, DV, MK, DV};
  endfunction

  function automatic logic [3:0] dummy_exp(input logic [7:0] o);
    return (o == 8'h03) ? 4'h0 : 4'h8;
  endfunction

  task automatic end_of_test;
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    starts = 0;
    resets = 0;
    rxs = 0;
    oe_seen = 1'b0;
    rst = 1'b1;
    arr_busy = 1'b0;
    arr_done = 1'b0;
    stat_hi = 6'h00;
    void'($urandom(32'h0ddc));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk("wel_reset", write_latch_bit, 1'b0);
    chk("fm_reset", factory_mode, 1'b0);
    send(64'h00C, 9);
    chk("wel_off_boundary", write_latch_bit, 1'b0);
    addr = 24'($urandom);
    s0 = starts;
    send({8'h20, addr}, 32);
    chk("wipe_no_latch", starts, s0);
    send(64'h06, 8);
    chk("wel_set", write_latch_bit, 1'b1);
    stat_hi <= 6'($urandom);
    send(64'h0500, 16);
    chk("status_wel", d[7:0], {stat_hi, 1'b1, 1'b0});
    send(64'h41, 8);
    chk("fm_set", factory_mode, 1'b1);
    send({8'h20, addr}, 32);
    chk("wipe_start", starts, s0 + 1);
    chk("wipe_op", arr_op, 8'h20);
    chk("wipe_addr", arr_addr, addr);
    finish_op();
    chk("wel_after_wipe", write_latch_bit, 1'b0);
    chk("fm_after_wipe", factory_mode, 1'b0);
    send(64'h06, 8);
    send(64'h41, 8);
    op = 8'($urandom);
    s0 = rxs;
    send({8'h02, addr, op}, 40);
    chk("page_op", arr_op, 8'h02);
    chk("page_data", rx_byte, op);
    chk("page_data_cnt", rxs, s0 + 1);
    finish_op();
    chk("wel_after_page", write_latch_bit, 1'b0);
    chk("fm_after_page", factory_mode, 1'b0);
    send(64'h06, 8);
    send(64'h41, 8);
    op = 8'($urandom);
    s0 = starts;
    send({8'h01, op}, 16);
    chk("stwr_start", starts, s0 + 1);
    chk("stwr_data", rx_byte, op);
    finish_op();
    chk("wel_after_stwr", write_latch_bit, 1'b0);
    chk("fm_kept_stwr", factory_mode, 1'b1);
    send(64'h06, 8);
    send(64'h60, 8);
    chk("chip_wipe_op", arr_op, 8'h60);
    finish_op();
    chk("wel_after_chip", write_latch_bit, 1'b0);
    chk("fm_after_chip", factory_mode, 1'b0);
    send(64'h06, 8);
    send(64'h04, 8);
    chk("wel_clear", write_latch_bit, 1'b0);
    send(64'h9F000000, 32);
    chk("id_read", d[23:0], {MK, MT, MD});
    send(64'h9F000, 20);
    chk("id_cut_short", d[11:0], {MK, MT[7:4]});
    arr_busy <= 1'b1;
    send(64'h9F000000, 32);
    chk("id_while_busy", oe_seen, 1'b0);
    arr_busy <= 1'b0;
    send(64'hFF00, 16);
    chk("unknown_opcode", oe_seen, 1'b0);
    send({8'hAB, 24'($urandom), 16'h0}, 48);
    chk("signature_twice", d[15:0], {DV, DV});
    send(64'hB9, 8);
    chk("sleep_set", deep_sleep, 1'b1);
    send(64'hAB, 8);
    chk("sleep_release", deep_sleep, 1'b0);
    for (int a = 0; a < 2; a++)
    begin
      send({8'h90, 16'($urandom), 8'(a), 32'h0}, 64);
      chk("maker_device", d[31:0], md_exp(8'(a)));
    end
    s0 = resets;
    send(64'h66, 8);
    send(64'h99, 8);
    chk("reset_fire", resets, s0 + 1);
    send(64'h66, 8);
    send(64'h0500, 16);
    send(64'h99, 8);
    chk("reset_fire_broken", resets, s0 + 1);
    repeat (6)
    begin
      // random opcodes only from defined set
      case ($urandom % 4)
        0: op = 8'h03;
        1: op = 8'h0B;
        2: op = 8'h3B;
        default: op = 8'h5A;
      endcase
      addr = 24'($urandom);
      send({op, addr}, 32);
      chk("read_op", arr_op, op);
      chk("read_addr", arr_addr, addr);
      chk("read_dummy", arr_dummy, dummy_exp(op));
    end
    end_of_test();
  end
endmodule
